// ---- inc/dad_pkg.sv ----
/*
 * Shared types and constants of the datagram address decoder: datagram
 * header carrier, local memory port, mapping-unit window, command codes.
 * Assumes a single clock domain shared by every user of the package.
 */
package dad_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int LOG_W  = 32;

    // Command codes handled by the decoder.
    localparam logic [7:0] CMD_NOP  = 8'h00;
    localparam logic [7:0] CMD_APRD = 8'h01;
    localparam logic [7:0] CMD_APWR = 8'h02;
    localparam logic [7:0] CMD_APRW = 8'h03;
    localparam logic [7:0] CMD_FPRD = 8'h04;
    localparam logic [7:0] CMD_FPWR = 8'h05;
    localparam logic [7:0] CMD_BRD  = 8'h07;
    localparam logic [7:0] CMD_BWR  = 8'h08;
    localparam logic [7:0] CMD_BRW  = 8'h09;
    localparam logic [7:0] CMD_LRD  = 8'h0A;
    localparam logic [7:0] CMD_LWR  = 8'h0B;
    localparam logic [7:0] CMD_LRW  = 8'h0C;

    localparam logic [15:0] POS_INC      = 16'h0001;
    localparam logic [15:0] POS_HIT      = 16'h0000;
    localparam logic [15:0] WKC_INC_RD   = 16'h0001;
    localparam logic [15:0] WKC_INC_WR   = 16'h0001;
    localparam logic [15:0] WKC_INC_RWWR = 16'h0002;
    localparam logic [15:0] ALIAS_RESET  = 16'h0000;

    typedef struct packed {
        logic [7:0]        cmd;
        logic [7:0]        idx;
        logic [15:0]       adp;
        logic [15:0]       ado;
        logic [DATA_W-1:0] data;
        logic [15:0]       wkc;
    } dad_dgram_t;

    typedef struct packed {
        logic              req;
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } dad_mem_t;

    typedef struct packed {
        logic              en;
        logic [LOG_W-1:0]  start;
        logic [15:0]       len;
        logic [ADDR_W-1:0] phys;
    } dad_map_t;

    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_READ  = 2'b01,
        S_WRITE = 2'b11,
        S_SEND  = 2'b10
    } dad_state_t;

endpackage

// ---- logic/dad_log_match.sv ----
/*
 * Logical address matcher: compares a 32-bit logical address against
 * every enabled mapping unit and returns the first hit with its local
 * address. Purely combinational; the window table comes from outside.
 */
`timescale 1ns/1ps
module dad_log_match #(
    parameter int NUM_MAP = 4
) (
    input  dad_pkg::dad_map_t                   maps [NUM_MAP],
    input  wire logic [dad_pkg::LOG_W-1:0]      addr,
    output logic                                hit,
    output logic [dad_pkg::ADDR_W-1:0]          laddr
);
    import dad_pkg::*;

    logic [NUM_MAP-1:0] unit_hit;
    logic [ADDR_W-1:0]  unit_addr [NUM_MAP];

    if (NUM_MAP < 1) begin : g_bad
        $error("dad_log_match needs at least one mapping unit.");
    end

    for (genvar i = 0; i < NUM_MAP; i++) begin : g_unit
        logic [LOG_W-1:0] diff;
        assign diff = addr - maps[i].start;
        // Lower bound is compared directly; the unsigned difference is checked against the length.
        assign unit_hit[i] = maps[i].en && (addr >= maps[i].start)
                             && (diff < LOG_W'(maps[i].len));
        assign unit_addr[i] = maps[i].phys + diff[ADDR_W-1:0];
    end

    // Lowest unit wins when windows overlap.
    always_comb begin
        hit   = 1'b0;
        laddr = '0;
        for (int i = NUM_MAP - 1; i >= 0; i--) begin
            if (unit_hit[i]) begin
                hit   = 1'b1;
                laddr = unit_addr[i];
            end
        end
    end

endmodule

// ---- logic/dad_decoder.sv ----
/*
 * Datagram address decoder: takes one datagram header with its data word,
 * decides whether it addresses this node, runs the local access and hands
 * the updated datagram on. Assumes the memory port answers on mclk
 * and that all inputs come from logic on mclk.
 */
// How it works
// - Serves node addressing and logical addressing of mapped space.
// - Node variants: auto-increment position, station address, broadcast.
// - Holds a master station address and an application-writable alias.
// - Storage alias is taken only on the first load after reset.
// - Position gets plus one; hit when the received position is zero.
// - Station mode hits on station address, or alias while alias enabled.
// - Broadcast increments position but never uses it for addressing.
// - Logical mode hits only inside a mapping unit window.
// - Device-addressed commands use the offset field as local address.
// - Command 00h performs no access and leaves the datagram unchanged.
// - Command 01h reads on position zero; position always increments.
// - Command 02h writes on position zero; position always increments.
// - Command 03h swaps datagram and local data on position zero.
// - Command 04h reads local data when the station address matches.
// - Command 05h writes datagram data when the station address matches.
// - Working counter +1 per read or write; read-write adds 1 and 2.
`timescale 1ns/1ps
module dad_decoder #(
    parameter int NUM_MAP = 4
) (
    input  wire logic                           mclk,
    input  wire logic                           reset_n,
    input  dad_pkg::dad_dgram_t                 dg_in,
    input  wire logic                           dg_in_valid,
    output logic                                dg_in_ready,
    output dad_pkg::dad_dgram_t                 dg_out,
    output logic                                dg_out_valid,
    input  wire logic                           dg_out_ready,
    output dad_pkg::dad_mem_t                   mem,
    input  wire logic [dad_pkg::DATA_W-1:0]     mem_rdata,
    input  wire logic                           mem_ack,
    input  wire logic [15:0]                    station_addr,
    input  wire logic                           alias_en,
    input  wire logic                           store_load,
    input  wire logic [15:0]                    store_alias,
    input  wire logic                           app_alias_we,
    input  wire logic [15:0]                    app_alias,
    output logic [15:0]                         alias_addr,
    input  dad_pkg::dad_map_t                   maps [NUM_MAP]
);
    import dad_pkg::*;

    typedef struct packed {
        dad_state_t        st;
        dad_dgram_t        dg;
        dad_dgram_t        orig;
        logic              hit;
        logic [ADDR_W-1:0] laddr;
        logic [15:0]       alias_val;
        logic              alias_loaded;
    } dad_regs_t;

    dad_regs_t s_q;
    dad_regs_t s_d;

    function automatic logic is_pos(input logic [7:0] c);
        return c == CMD_APRD || c == CMD_APWR || c == CMD_APRW;
    endfunction
    function automatic logic is_node(input logic [7:0] c);
        return c == CMD_FPRD || c == CMD_FPWR;
    endfunction
    function automatic logic is_bcast(input logic [7:0] c);
        return c == CMD_BRD || c == CMD_BWR || c == CMD_BRW;
    endfunction
    function automatic logic is_log(input logic [7:0] c);
        return c == CMD_LRD || c == CMD_LWR || c == CMD_LRW;
    endfunction
    function automatic logic does_rd(input logic [7:0] c);
        return c == CMD_APRD || c == CMD_APRW || c == CMD_FPRD
               || c == CMD_LRD || c == CMD_LRW;
    endfunction
    function automatic logic does_wr(input logic [7:0] c);
        return c == CMD_APWR || c == CMD_APRW || c == CMD_FPWR
               || c == CMD_LWR || c == CMD_LRW;
    endfunction

    logic              log_hit;
    logic [ADDR_W-1:0] log_addr;
    logic              pos_hit;
    logic              node_hit;
    logic              dev_hit;

    dad_log_match #(
        .NUM_MAP (NUM_MAP)
    ) u_match (
        .maps  (maps),
        .addr  ({dg_in.ado, dg_in.adp}),
        .hit   (log_hit),
        .laddr (log_addr)
    );

    assign pos_hit  = dg_in.adp == POS_HIT;
    assign node_hit = dg_in.adp == station_addr
                      || (alias_en && dg_in.adp == s_q.alias_val);
    // Broadcast codes are not executed here, so they never count as hits.
    assign dev_hit = (is_pos(dg_in.cmd) && pos_hit)
                     || (is_node(dg_in.cmd) && node_hit)
                     || (is_log(dg_in.cmd) && log_hit);

    always_comb begin
        s_d         = s_q;
        dg_in_ready = s_q.st == S_IDLE;
        mem.req     = s_q.st == S_READ || s_q.st == S_WRITE;
        mem.we      = s_q.st == S_WRITE;
        mem.addr    = s_q.laddr;
        mem.wdata   = s_q.orig.data;

        // Application writes first, so a first storage load in the same
        // cycle still lands; later loads are ignored.
        if (app_alias_we) begin
            s_d.alias_val = app_alias;
        end
        if (store_load && !s_q.alias_loaded) begin
            s_d.alias_val    = store_alias;
            s_d.alias_loaded = 1'b1;
        end

        unique case (s_q.st)
            S_IDLE: begin
                if (dg_in_valid) begin
                    s_d.orig  = dg_in;
                    s_d.dg    = dg_in;
                    s_d.hit   = dev_hit;
                    s_d.laddr = is_log(dg_in.cmd) ? log_addr
                                                  : dg_in.ado;
                    if (is_pos(dg_in.cmd) || is_bcast(dg_in.cmd)) begin
                        s_d.dg.adp = dg_in.adp + POS_INC;
                    end
                    if (dev_hit && does_rd(dg_in.cmd)) begin
                        s_d.st = S_READ;
                    end else if (dev_hit && does_wr(dg_in.cmd)) begin
                        s_d.st = S_WRITE;
                    end else begin
                        s_d.st = S_SEND;
                    end
                end
            end
            S_READ: begin
                if (mem_ack) begin
                    s_d.dg.data = mem_rdata;
                    s_d.dg.wkc  = s_q.dg.wkc + WKC_INC_RD;
                    s_d.st      = does_wr(s_q.orig.cmd) ? S_WRITE : S_SEND;
                end
            end
            S_WRITE: begin
                if (mem_ack) begin
                    s_d.dg.wkc = s_q.dg.wkc + (does_rd(s_q.orig.cmd)
                                 ? WKC_INC_RWWR : WKC_INC_WR);
                    s_d.st     = S_SEND;
                end
            end
            S_SEND: begin
                if (dg_out_ready) begin
                    s_d.st = S_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '{st: S_IDLE, alias_val: ALIAS_RESET, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign dg_out       = s_q.dg;
    assign dg_out_valid = s_q.st == S_SEND;
    assign alias_addr   = s_q.alias_val;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence rd_done;
        mem.req && !mem.we && mem_ack;
    endsequence
    sequence wr_start;
        mem.req && mem.we;
    endsequence

    a_nop_no_access: assert property (
        dg_in_valid && dg_in_ready && dg_in.cmd == CMD_NOP
        |=> dg_out_valid && dg_out == $past(dg_in))
        else $error("No-operation datagram was altered or delayed.");

    a_pos_increment: assert property (
        dg_out_valid && is_pos(s_q.orig.cmd)
        |-> dg_out.adp == s_q.orig.adp + POS_INC)
        else $error("Position field not incremented by one.");

    a_bcast_no_use: assert property (
        dg_in_valid && dg_in_ready && is_bcast(dg_in.cmd)
        |=> !mem.req && dg_out.adp == $past(dg_in.adp) + POS_INC)
        else $error("Broadcast position handled wrongly.");

    a_miss_untouched: assert property (
        dg_out_valid && !s_q.hit
        |-> dg_out.data == s_q.orig.data && dg_out.wkc == s_q.orig.wkc)
        else $error("Unaddressed datagram was modified.");

    a_swap_order: assert property (
        rd_done ##0 (s_q.orig.cmd == CMD_APRW) |=> wr_start)
        else $error("Read-write did not follow read with write.");

    a_rw_counter: assert property (
        dg_out_valid && s_q.hit && s_q.orig.cmd == CMD_APRW
        |-> dg_out.wkc == s_q.orig.wkc + WKC_INC_RD + WKC_INC_RWWR)
        else $error("Read-write working counter not raised by three.");

    a_node_read: assert property (
        dg_in_valid && dg_in_ready && dg_in.cmd == CMD_FPRD
        && dg_in.adp == station_addr |=> mem.req && !mem.we)
        else $error("Station read did not start a local read.");

    a_offset_addr: assert property (
        mem.req && !is_log(s_q.orig.cmd) |-> mem.addr == s_q.orig.ado)
        else $error("Local address differs from offset field.");

    a_alias_once: assert property (
        s_q.alias_loaded && store_load && !app_alias_we
        |=> $stable(alias_addr))
        else $error("Later storage load replaced the alias.");

    a_log_gate: assert property (
        dg_in_valid && dg_in_ready && is_log(dg_in.cmd) && !log_hit
        |=> !mem.req [*2])
        else $error("Logical access without a window match.");

endmodule

// ---- bench/dad_mem_model.sv ----
/*
 * Behavioural local memory behind the decoder's access port.
 * Assumes one access at a time, held by the decoder until acknowledged.
 */
`timescale 1ns/1ps
module dad_mem_model (
    input  wire logic          mclk,
    input  wire logic          reset_n,
    input  dad_pkg::dad_mem_t  mem,
    input  wire logic [3:0]    lat,
    output logic [31:0]        rdata,
    output logic               ack
);
    import dad_pkg::*;
    logic [31:0] store [16];
    logic [3:0]  cnt;

    // Read data is only valid with ack; otherwise it toggles so stale use shows.
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ack <= 1'b0;
            cnt <= 4'h0;
            rdata <= 32'h5A5A_5A5A;
            for (int i = 0; i < 16; i++) store[i] <= {16'hC0DE, 16'(i)};
        end else if (mem.req && !ack && cnt >= lat) begin
            ack <= 1'b1;
            cnt <= 4'h0;
            rdata <= store[mem.addr[3:0]];
            if (mem.we) store[mem.addr[3:0]] <= mem.wdata;
        end else begin
            ack <= 1'b0;
            rdata <= ~rdata;
            cnt <= (mem.req && !ack) ? cnt + 4'h1 : 4'h0;
        end
    end
endmodule

// ---- bench/tb_dad_decoder.sv ----
/*
 * Self-checking bench of the datagram address decoder: a table of
 * datagrams, then alias, slow memory, stalled output and mid-run reset.
 * Assumes the memory model starts every word at C0DE and its index.
 */
`timescale 1ns/1ps
`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin \
    miscompares++; $display("[FAIL] %0t %s", $time, m); end end
module tb_dad_decoder;
    import dad_pkg::*;
    typedef struct packed {
        logic [7:0]  cmd;
        logic [15:0] adp;
        logic [15:0] ado;
        logic [31:0] data;
        logic [15:0] wkc;
        logic [15:0] e_adp;
        logic [31:0] e_data;
        logic [15:0] e_wkc;
    } dad_row_t;
    logic        mclk, reset_n, dg_in_valid, dg_in_ready, dg_out_valid;
    logic        dg_out_ready, mem_ack, alias_en, store_load, app_alias_we;
    logic [31:0] mem_rdata;
    logic [15:0] station_addr, store_alias, app_alias, alias_addr;
    logic [3:0]  lat;
    int          stall, checks, miscompares, cycles;
    dad_dgram_t  dg_in, dg_out, q, e;
    dad_mem_t    mem;
    dad_map_t    maps [4];
    dad_row_t    rows [17] = '{
        '{CMD_NOP, 16'h0005, 16'h0003, 32'h0000_0011, 16'h0000,
          16'h0005, 32'h0000_0011, 16'h0000},
        '{CMD_APRD, 16'h0000, 16'h0003, 32'h0, 16'h0005,
          16'h0001, 32'hC0DE_0003, 16'h0006},
        '{CMD_APRD, 16'hFFFF, 16'h0003, 32'h0, 16'h0000,
          16'h0000, 32'h0, 16'h0000},
        '{CMD_APWR, 16'h0000, 16'h0004, 32'hDEAD_BEEF, 16'h0000,
          16'h0001, 32'hDEAD_BEEF, 16'h0001},
        '{CMD_APRD, 16'h0000, 16'h0004, 32'h0, 16'h0000,
          16'h0001, 32'hDEAD_BEEF, 16'h0001},
        '{CMD_APRW, 16'h0000, 16'h0005, 32'h1111_2222, 16'h0000,
          16'h0001, 32'hC0DE_0005, 16'h0003},
        '{CMD_FPRD, 16'h0042, 16'h0005, 32'h0, 16'h0000,
          16'h0042, 32'h1111_2222, 16'h0001},
        '{CMD_FPWR, 16'h0042, 16'h0006, 32'h3333_4444, 16'h0000,
          16'h0042, 32'h3333_4444, 16'h0001},
        '{CMD_FPRD, 16'h0043, 16'h0006, 32'h0, 16'h0000,
          16'h0043, 32'h0, 16'h0000},
        '{CMD_FPRD, 16'h0077, 16'h0006, 32'h0, 16'h0000,
          16'h0077, 32'h3333_4444, 16'h0001},
        '{CMD_BRD, 16'h0007, 16'h0003, 32'h0, 16'h0000,
          16'h0008, 32'h0, 16'h0000},
        '{CMD_LRD, 16'h0002, 16'h0001, 32'h0, 16'h0000,
          16'h0002, 32'hC0DE_000A, 16'h0001},
        '{CMD_LRD, 16'h0010, 16'h0001, 32'h0, 16'h0000,
          16'h0010, 32'h0, 16'h0000},
        '{8'h06, 16'h0042, 16'h0003, 32'h0, 16'h0000,
          16'h0042, 32'h0, 16'h0000},
        '{CMD_LWR, 16'h0003, 16'h0001, 32'h5555_6666, 16'h0000,
          16'h0003, 32'h5555_6666, 16'h0001},
        '{CMD_LRW, 16'h0003, 16'h0001, 32'h7777_8888, 16'h0000,
          16'h0003, 32'h5555_6666, 16'h0003},
        '{CMD_BWR, 16'hFFFF, 16'h0003, 32'h0, 16'h0000,
          16'h0000, 32'h0, 16'h0000}};

    dad_decoder #(.NUM_MAP(4)) dut (.mclk(mclk), .reset_n(reset_n),
        .dg_in(dg_in), .dg_in_valid(dg_in_valid), .dg_in_ready(dg_in_ready),
        .dg_out(dg_out), .dg_out_valid(dg_out_valid),
        .dg_out_ready(dg_out_ready), .mem(mem), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack), .station_addr(station_addr),
        .alias_en(alias_en), .store_load(store_load),
        .store_alias(store_alias), .app_alias_we(app_alias_we),
        .app_alias(app_alias), .alias_addr(alias_addr), .maps(maps));
    dad_mem_model far (.mclk(mclk), .reset_n(reset_n), .mem(mem),
        .lat(lat), .rdata(mem_rdata), .ack(mem_ack));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // The ceiling is far above the roughly 120 cycles the tests need.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic do_reset();
        reset_n = 1'b0;
        repeat (2) @(negedge mclk);
        `CHK({dg_in_ready, dg_out_valid, mem.req}, 3'b100, "reset outputs")
        `CHK(alias_addr, ALIAS_RESET, "reset alias")
        reset_n = 1'b1;
        @(negedge mclk);
    endtask

    task automatic load(input logic [15:0] v, input logic app);
        store_alias = v;
        app_alias = v;
        store_load = !app;
        app_alias_we = app;
        @(negedge mclk);
        store_load = 1'b0;
        app_alias_we = 1'b0;
        @(negedge mclk);
    endtask

    // Presents one datagram, waits for the answer, holds it for stall cycles.
    task automatic xfer(input dad_dgram_t d, output dad_dgram_t r);
        int n;
        n = 0;
        dg_in = d;
        dg_in_valid = 1'b1;
        while (dg_in_ready !== 1'b1 && n < 100) begin
            @(negedge mclk);
            n++;
        end
        @(negedge mclk);
        dg_in_valid = 1'b0;
        while (dg_out_valid !== 1'b1 && n < 100) begin
            @(negedge mclk);
            n++;
        end
        repeat (stall) @(negedge mclk);
        `CHK(dg_out_valid, 1'b1, "answer lost")
        r = dg_out;
        dg_out_ready = 1'b1;
        @(negedge mclk);
        dg_out_ready = 1'b0;
    endtask

    task automatic run(input dad_row_t w, input logic [7:0] id);
        e = '{w.cmd, id, w.adp, w.ado, w.data, w.wkc};
        xfer(e, q);
        e.adp = w.e_adp;
        e.data = w.e_data;
        e.wkc = w.e_wkc;
    endtask

    initial begin
        {reset_n, dg_in_valid, dg_out_ready, store_load, app_alias_we} = '0;
        {dg_in, cycles, checks, miscompares, stall, lat} = '0;
        {store_alias, app_alias} = '0;
        station_addr = 16'h0042;
        alias_en = 1'b1;
        maps[0] = '{1'b1, 32'h0001_0000, 16'h0010, 16'h0008};
        for (int i = 1; i < 4; i++) maps[i] = '0;
        do_reset();
        load(16'h0077, 1'b0);
        load(16'h0099, 1'b0);
        `CHK(alias_addr, 16'h0077, "second load taken")
        for (int i = 0; i < 17; i++) begin
            run(rows[i], 8'(i));
            `CHK(q, e, "row")
        end
        load(16'h0055, 1'b1);
        `CHK(alias_addr, 16'h0055, "app alias")
        alias_en = 1'b0;
        run('{CMD_FPRD, 16'h0055, 16'h0003, 32'h0, 16'h0000,
              16'h0055, 32'h0, 16'h0000}, 8'h20);
        `CHK(q, e, "alias disabled")
        lat = 4'h5;
        stall = 3;
        run('{CMD_APRW, 16'h0000, 16'h0007, 32'h0BAD_F00D, 16'h0010,
              16'h0001, 32'hC0DE_0007, 16'h0013}, 8'h21);
        `CHK(q, e, "slow swap")
        run('{CMD_FPRD, 16'h0042, 16'h0007, 32'h0, 16'h0000,
              16'h0042, 32'h0BAD_F00D, 16'h0001}, 8'h22);
        `CHK(q, e, "swap stored")
        // The model folds local address 17h onto word 7, left by the swap.
        run('{CMD_LRD, 16'h000F, 16'h0001, 32'h0, 16'h0002,
              16'h000F, 32'h0BAD_F00D, 16'h0003}, 8'h23);
        `CHK(q, e, "last window word")
        do_reset();
        load(16'h0099, 1'b0);
        `CHK(alias_addr, 16'h0099, "load after reset")
        tally_and_finish();
    end
endmodule
